/* File: core/isf_pkg.sv */
// constants and carrier types of the spike filter and repeated start clear block
//
// Overview of operation
// - Pulses on clock or data no longer than the glitch length are removed.
// - Glitch length accepts writes only while the controller is disabled.
// - Writing zero to the glitch length stores one instead.
// - Reading the clear register clears repeated start flag, returns it in bit 0.
package isf_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ISF_CTRL_OFS = 8'h6C;
	localparam logic [7:0] ISF_IRQ_EN_OFS = 8'h30;
	localparam logic [7:0] ISF_RAW_STAT_OFS = 8'h34;
	localparam logic [7:0] ISF_IRQ_CLR_OFS = 8'h40;
	localparam logic [7:0] ISF_STD_FAST_OFS = 8'hA0;
	localparam logic [7:0] ISF_HIGH_SPEED_OFS = 8'hA4;
	localparam logic [7:0] ISF_RESTART_CLR_OFS = 8'hA8;

	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int ISF_CTRL_EN_BIT = 0;
	localparam int ISF_SPIKE_BIT = 0;
	localparam int ISF_RESTART_BIT = 12;
	localparam int ISF_STAT_W = 13;
	localparam int ISF_LEN_W = 8;
	localparam logic [7:0] ISF_LEN_RST = 8'h00;
	localparam logic [7:0] ISF_LEN_MIN = 8'h01;
	localparam logic [12:0] ISF_STAT_RST = 13'h0000;
	localparam int ISF_SCL = 0;
	localparam int ISF_SDA = 1;

	// apb request as seen by the slave
	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} isf_apb_req_t;

	// apb answer
	typedef struct packed
	{
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} isf_apb_rsp_t;
endpackage

/* File: core/isf_spike_filter.sv */
// glitch filter, repeated start detector and their registers behind apb
`timescale 1ns/100ps
`default_nettype none
module isf_spike_filter
(
	input wire logic core_clk, // 100 MHz clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire isf_pkg::isf_apb_req_t apbReq, // apb request
	output var isf_pkg::isf_apb_rsp_t apbRsp, // apb answer
	input wire logic sclIn, // clock line level from the pin
	input wire logic sdaIn, // data line level from the pin
	output logic sclFilt, // filtered clock line
	output logic sdaFilt, // filtered data line
	output logic ctrlEnable, // controller enable bit
	output logic irq // level interrupt
);
	import isf_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed
	{
		logic [7:0] glitchLimit;
		logic ctrlEn;
		logic [12:0] rawStatus;
		logic [12:0] irqEnable;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] filt;
		logic [1:0][7:0] cnt;
		logic busBusy;
		logic irqOut;
		isf_apb_rsp_t rsp;
	} isf_state_t;

	isf_state_t st;
	isf_state_t next_st;
	logic access;
	logic done;
	logic [7:0] addr;
	logic [12:0] events;
	logic [12:0] clrMask;
	logic startCond;
	logic stopCond;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		access = apbReq.psel && apbReq.penable;
		done = access && st.rsp.pready;
		addr = apbReq.paddr;
		events = ISF_STAT_RST;
		clrMask = ISF_STAT_RST;

		// two stage synchronisers, then length-qualified change
		next_st.sync1 = {sdaIn, sclIn};
		next_st.sync2 = st.sync1;
		for (int i = 0; i < 2; i++)
		begin
			if (st.sync2[i] == st.filt[i])
				next_st.cnt[i] = 8'h00;
			else if (st.cnt[i] >= st.glitchLimit)
			begin
				next_st.filt[i] = st.sync2[i];
				next_st.cnt[i] = 8'h00;
			end
			else
				next_st.cnt[i] = st.cnt[i] + 8'h01;
		end

		// a pulse that dies before qualifying counts as a suppressed spike
		for (int i = 0; i < 2; i++)
		begin
			if (st.sync2[i] == st.filt[i] && st.cnt[i] != 8'h00)
				events[ISF_SPIKE_BIT] = 1'b1;
		end

		// start and stop on the filtered lines
		startCond = st.filt[ISF_SDA] && !next_st.filt[ISF_SDA]
			&& st.filt[ISF_SCL] && next_st.filt[ISF_SCL];
		stopCond = !st.filt[ISF_SDA] && next_st.filt[ISF_SDA]
			&& st.filt[ISF_SCL] && next_st.filt[ISF_SCL];
		if (startCond)
			next_st.busBusy = 1'b1;
		else if (stopCond)
			next_st.busBusy = 1'b0;
		events[ISF_RESTART_BIT] = startCond && st.busBusy;

		// apb: one wait cycle, read data prepared on the first access cycle
		next_st.rsp.pready = access && !st.rsp.pready;
		next_st.rsp.pslverr = 1'b0;
		next_st.rsp.prdata = 32'h0000_0000;
		if (access && !st.rsp.pready && !apbReq.pwrite)
		begin
			unique case (addr)
				ISF_CTRL_OFS: next_st.rsp.prdata[ISF_CTRL_EN_BIT] = st.ctrlEn;
				ISF_IRQ_EN_OFS: next_st.rsp.prdata[12:0] = st.irqEnable;
				ISF_RAW_STAT_OFS: next_st.rsp.prdata[12:0] = st.rawStatus;
				ISF_IRQ_CLR_OFS: next_st.rsp.prdata = 32'h0000_0000;
				ISF_STD_FAST_OFS: next_st.rsp.prdata[7:0] = st.glitchLimit;
				ISF_HIGH_SPEED_OFS: next_st.rsp.prdata = 32'h0000_0000;
				ISF_RESTART_CLR_OFS: next_st.rsp.prdata[0] = st.rawStatus[ISF_RESTART_BIT];
				default: next_st.rsp.pslverr = 1'b1;
			endcase
		end
		else if (access && !st.rsp.pready)
		begin
			unique case (addr)
				ISF_CTRL_OFS, ISF_IRQ_EN_OFS, ISF_RAW_STAT_OFS, ISF_IRQ_CLR_OFS,
				ISF_STD_FAST_OFS, ISF_HIGH_SPEED_OFS, ISF_RESTART_CLR_OFS:
					next_st.rsp.pslverr = 1'b0;
				default: next_st.rsp.pslverr = 1'b1;
			endcase
		end

		// register effects at the completing edge
		if (done && apbReq.pwrite)
		begin
			unique case (addr)
				ISF_CTRL_OFS: next_st.ctrlEn = apbReq.pwdata[ISF_CTRL_EN_BIT];
				ISF_IRQ_EN_OFS: next_st.irqEnable = apbReq.pwdata[12:0];
				ISF_IRQ_CLR_OFS: clrMask = apbReq.pwdata[12:0];
				ISF_STD_FAST_OFS:
				begin
					if (!st.ctrlEn)
					begin
						if (apbReq.pwdata[7:0] < ISF_LEN_MIN)
							next_st.glitchLimit = ISF_LEN_MIN;
						else
							next_st.glitchLimit = apbReq.pwdata[7:0];
					end
				end
				default: clrMask = ISF_STAT_RST; // high speed limit and others: no effect
			endcase
		end
		else if (done && addr == ISF_RESTART_CLR_OFS)
			clrMask[ISF_RESTART_BIT] = st.rsp.prdata[0];

		// sticky status, a new event wins over a clear
		next_st.rawStatus = (st.rawStatus & ~clrMask) | events;
		next_st.irqOut = |(next_st.rawStatus & next_st.irqEnable);
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.glitchLimit <= ISF_LEN_RST;
			st.sync1 <= 2'h3;
			st.sync2 <= 2'h3;
			st.filt <= 2'h3;
		end
		else if (ce)
			st <= next_st;
	end

	// outputs straight from state
	assign apbRsp = st.rsp;
	assign sclFilt = st.filt[ISF_SCL];
	assign sdaFilt = st.filt[ISF_SDA];
	assign ctrlEnable = st.ctrlEn;
	assign irq = st.irqOut;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	short_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.sync2[ISF_SDA] != st.filt[ISF_SDA] && st.cnt[ISF_SDA] < st.glitchLimit
		|=> $stable(st.filt[ISF_SDA]))
		else $error("short data pulse passed the filter");
	limit_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.ctrlEn && $past(st.ctrlEn) |-> $stable(st.glitchLimit))
		else $error("glitch length changed while enabled");
	limit_floor_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && done && apbReq.pwrite && addr == ISF_STD_FAST_OFS && !st.ctrlEn
		&& apbReq.pwdata[7:0] == 8'h00 |=> st.glitchLimit == ISF_LEN_MIN)
		else $error("zero glitch length was stored");
	restart_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && done && !apbReq.pwrite && addr == ISF_RESTART_CLR_OFS && apbRsp.prdata[0]
		&& !events[ISF_RESTART_BIT] |=> !st.rawStatus[ISF_RESTART_BIT])
		else $error("repeated start flag survived its clear read");
	high_speed_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		done && !apbReq.pwrite && addr == ISF_HIGH_SPEED_OFS |-> apbRsp.prdata == 32'h0000_0000)
		else $error("high speed limit read nonzero");
endmodule
`default_nettype wire

/* File: verification/isf_bus_party.sv */
// model of the remote parties on the clock and data lines
`timescale 1ns/100ps
`default_nettype none
module isf_bus_party
(
	input wire logic core_clk, // bench clock
	output var logic scl, // clock line, pulled up
	output var logic sda // data line, pulled up
);
	// released lines sit at the pull-up level
	initial
	begin
		scl = 1'h1;
		sda = 1'h1;
	end
	// hold a level pair long enough to pass any short limit
	task hold(input logic s, input logic d);
		scl <= s;
		sda <= d;
		repeat (10) @(posedge core_clk);
	endtask
	// low data pulse of w cycles while the clock is high
	task spike(input int w);
		sda <= 1'h0;
		repeat (w) @(posedge core_clk);
		sda <= 1'h1;
		repeat (12) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

/* File: verification/isf_spike_filter_bench.sv */
// self-checking bench for the glitch filter and repeated start clear
`timescale 1ns/100ps
`default_nettype none
module isf_spike_filter_bench;
	import isf_pkg::*;
	logic core_clk, rst_n, ce, sclIn, sdaIn, sclFilt, sdaFilt, ctrlEnable, irq, sawLow, err;
	isf_apb_req_t apbReq;
	isf_apb_rsp_t apbRsp;
	logic [31:0] rd;
	int fails, totalChecks;
	isf_spike_filter uut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .apbReq(apbReq),
		.apbRsp(apbRsp), .sclIn(sclIn), .sdaIn(sdaIn), .sclFilt(sclFilt), .sdaFilt(sdaFilt),
		.ctrlEnable(ctrlEnable), .irq(irq));
	isf_bus_party bus (.core_clk(core_clk), .scl(sclIn), .sda(sdaIn));
	// clock
	initial
	begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	// note any low level on filtered data
	always @(posedge core_clk)
		if (!rst_n)
			sawLow <= 1'h0;
		else if (sdaFilt === 1'h0)
			sawLow <= 1'h1;
	task give_verdict;
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer, request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		apbReq <= '{1'h1, 1'h0, w, a, d};
		@(posedge core_clk);
		apbReq.penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (apbRsp.pready !== 1'h1 && n < 20);
		if (apbRsp.pready !== 1'h1)
		begin
			fails++;
			give_verdict;
		end
		else
		begin
			// answer taken at the completing edge, then the request is dropped
			rd = apbRsp.prdata;
			err = apbRsp.pslverr;
			apbReq.psel <= 1'h0;
			apbReq.penable <= 1'h0;
			@(posedge core_clk);
		end
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, a, 32'h0000_0000);
		chk(rd & m, e);
	endtask
	// main sequence
	initial
	begin
		apbReq = '0;
		rst_n = 1'h0;
		ce = 1'h1;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
		rdchk(ISF_STD_FAST_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
		apb(1'h1, ISF_HIGH_SPEED_OFS, 32'hFFFF_FFFF);
		rdchk(ISF_HIGH_SPEED_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
		rdchk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
		chk(err, 32'h0000_0001);
		apb(1'h1, ISF_STD_FAST_OFS, 32'h0000_0000);
		rdchk(ISF_STD_FAST_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
		apb(1'h1, ISF_STD_FAST_OFS, 32'h0000_0103);
		rdchk(ISF_STD_FAST_OFS, 32'hFFFF_FFFF, 32'h0000_0003);
		apb(1'h1, ISF_CTRL_OFS, 32'h0000_0001);
		chk(ctrlEnable, 32'h0000_0001);
		apb(1'h1, ISF_STD_FAST_OFS, 32'h0000_0005);
		apb(1'h1, ISF_CTRL_OFS, 32'h0000_0000);
		chk(ctrlEnable, 32'h0000_0000);
		rdchk(ISF_STD_FAST_OFS, 32'hFFFF_FFFF, 32'h0000_0003);
		$display("test registers done");
		bus.spike(3);
		chk(sawLow, 32'h0000_0000);
		bus.spike(4);
		chk(sawLow, 32'h0000_0001);
		rdchk(ISF_RAW_STAT_OFS, 32'h0000_0001, 32'h0000_0001);
		apb(1'h1, ISF_IRQ_CLR_OFS, 32'h0000_0001);
		rdchk(ISF_RAW_STAT_OFS, 32'h0000_0001, 32'h0000_0000);
		$display("test filter done");
		// frozen block ignores a long low data level
		ce <= 1'h0;
		bus.hold(1'h1, 1'h0);
		chk(sdaFilt, 32'h0000_0001);
		bus.hold(1'h1, 1'h1);
		ce <= 1'h1;
		$display("test freeze done");
		// start, clock low, data high, clock high, data falls again
		apb(1'h1, ISF_IRQ_EN_OFS, 32'h0000_1000);
		bus.hold(1'h1, 1'h0);
		bus.hold(1'h0, 1'h0);
		chk(sclFilt, 32'h0000_0000);
		bus.hold(1'h0, 1'h1);
		bus.hold(1'h1, 1'h1);
		chk(irq, 32'h0000_0000);
		bus.hold(1'h1, 1'h0);
		chk(irq, 32'h0000_0001);
		rdchk(ISF_RESTART_CLR_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
		rdchk(ISF_RAW_STAT_OFS, 32'h0000_1000, 32'h0000_0000);
		chk(irq, 32'h0000_0000);
		rdchk(ISF_RESTART_CLR_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
		$display("test restart done");
		give_verdict;
	end
endmodule
`default_nettype wire
